// >>> rtl/sse_alu.sv
// subtract-with-borrow datapath with status flags
`timescale 1ns/1ps
module sse_alu (
    sse_alu_if.alu bus
);
    import sse_pkg::*;
    logic [8:0] full;
    logic [4:0] low;
    assign full = {1'b0, bus.w} + {1'b0, ~bus.f} + {8'h00, bus.flagsIn.c};
    assign low = {1'b0, bus.w[3:0]} + {1'b0, ~bus.f[3:0]} + {4'h0, bus.flagsIn.c};
    assign bus.result = full[7:0];
    always_comb begin
        bus.flagsOut.c = full[8];
        bus.flagsOut.dc = low[4];
        bus.flagsOut.z = (full[7:0] == 8'h00);
        bus.flagsOut.n = full[7];
        bus.flagsOut.ov = (bus.w[7] != bus.f[7]) && (full[7] != bus.w[7]);
    end
endmodule

// >>> rtl/sse_cfg.svh
// constants for the sleep and subtract-with-borrow executor
`ifndef SSE_CFG_SVH
`define SSE_CFG_SVH
`define SSE_OP_SLEEP 16'h0003
`define SSE_OP_SUBB 6'h15
`define SSE_F_OPHI 15:10
`define SSE_F_DEST 9
`define SSE_F_ACC 8
`define SSE_F_ADDR 7:0
`define SSE_ACC_SPLIT 8'h80
`define SSE_ACC_LO_BANK 4'h0
`define SSE_ACC_HI_BANK 4'hf
`define SSE_REG_CTRL 8'h00
`define SSE_REG_STAT 8'h04
`define SSE_REG_WREG 8'h08
`define SSE_REG_MADR 8'h0c
`define SSE_REG_MDAT 8'h10
`define SSE_REG_IRQS 8'h14
`define SSE_REG_IRQM 8'h18
`define SSE_CTRL_BANK 3:0
`define SSE_CTRL_WDOG_EN 4
`define SSE_STAT_FLAGS 4:0
`define SSE_STAT_POWERDOWN 5
`define SSE_STAT_TIMEOUT 6
`define SSE_STAT_SLP 7
`define SSE_POWERDOWN_RESET 1'b1
`define SSE_TIMEOUT_RESET 1'b1
`define SSE_CLK_NS 5
`define SSE_WDOG_PERIOD_NS 4000000
`define SSE_WDOG_CYCLES (`SSE_WDOG_PERIOD_NS / `SSE_CLK_NS)
`define SSE_WDOG_POSTSCALE 128
`endif

// >>> rtl/sse_exec.sv
// executor for the sleep and subtract-with-borrow instructions
// Function
// RULE_01 - executing sleep clears the power-down flag.
// RULE_02 - executing sleep sets the time-out flag.
// RULE_03 - executing sleep clears the watchdog counter and its postscaler.
// RULE_04 - after sleep the core halts its oscillator and runs no instruction until wake-up.
// RULE_05 - a wake-up caused by watchdog time-out clears the time-out flag.
// RULE_06 - sleep is the one-word one-cycle opcode 0x0003, idle in phase two, sleeping at phase four.
// RULE_07 - subtract-with-borrow computes W minus file register minus inverted carry.
// RULE_08 - destination bit zero writes W, one writes the file register.
// RULE_09 - access bit zero uses the access bank, one uses the bank select register.
`timescale 1ns/1ps
`include "sse_cfg.svh"
module sse_exec #(
    parameter int WDOG_BASE_CYCLES = `SSE_WDOG_CYCLES,
    parameter int WDOG_POSTSCALE = `SSE_WDOG_POSTSCALE
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic instrValid,
    input wire logic [15:0] instrWord,
    output logic instrReady,
    input wire logic wakePin,
    output logic oscRun,
    output logic irq
);
    import sse_pkg::*;
    sse_alu_if aluIf ();
    sse_wdog_if wdogIf ();
    sse_alu i_sse_alu (.bus(aluIf.alu));
    sse_watchdog #(.BASE_CYCLES(WDOG_BASE_CYCLES), .POSTSCALE(WDOG_POSTSCALE)) i_sse_watchdog (
        .clk(clk),
        .rst_n(rst_n),
        .ctl(wdogIf.wdog)
    );

    logic [7:0] fileMem [0:4095];
    sse_phase_type phase;
    sse_op_type op;
    logic [15:0] instr;
    logic asleep;
    logic powerdownFlag;
    logic timeoutFlag;
    sse_flags_type flags;
    logic [7:0] wReg;
    logic [7:0] fVal;
    logic [7:0] resReg;
    sse_flags_type resFlags;
    logic [3:0] bankSelectReg;
    logic wdogEn;
    logic [11:0] memAddr;
    logic [2:0] irqStat;
    logic [2:0] irqMask;
    logic wakeMeta;
    logic wakeSync;
    logic [11:0] fileAddr;
    logic sleepNow;
    logic subbNow;
    logic wdogWake;
    logic pinWake;
    logic busTake;
    logic busWr;
    logic [31:0] next_rdata;

    // wake pin crosses from outside the clock domain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wakeMeta <= 1'b0;
            wakeSync <= 1'b0;
        end else begin
            wakeMeta <= wakePin;
            wakeSync <= wakeMeta;
        end
    end

    assign sleepNow = (phase == PH_Q4) && (op == OP_SLEEP) && !asleep;
    assign subbNow = (phase == PH_Q4) && (op == OP_SUBB);
    assign wdogWake = asleep && wdogIf.timeout;
    assign pinWake = asleep && wakeSync && !wdogIf.timeout;
    assign instrReady = !asleep && (phase == PH_Q1);
    assign oscRun = !asleep;
    assign wdogIf.enable = wdogEn;
    assign wdogIf.clear = sleepNow; // [RULE_03]
    assign busTake = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign busWr = busTake && wb_we_i && wb_sel_i[0];

    // access bank splits low addresses to bank zero and high ones to the top bank
    always_comb begin
        if (instr[`SSE_F_ACC]) begin
            fileAddr = {bankSelectReg, instr[`SSE_F_ADDR]}; // [RULE_09]
        end else if (instr[`SSE_F_ADDR] < `SSE_ACC_SPLIT) begin
            fileAddr = {`SSE_ACC_LO_BANK, instr[`SSE_F_ADDR]}; // [RULE_09]
        end else begin
            fileAddr = {`SSE_ACC_HI_BANK, instr[`SSE_F_ADDR]}; // [RULE_09]
        end
    end

    // phase sequencer stops while the oscillator is halted
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= PH_Q1;
        end else if (sleepNow || asleep) begin
            phase <= PH_Q1; // [RULE_04]
        end else begin
            case (phase)
                PH_Q1: phase <= PH_Q2;
                PH_Q2: phase <= PH_Q3;
                PH_Q3: phase <= PH_Q4;
                PH_Q4: phase <= PH_Q1;
                default: phase <= PH_Q1;
            endcase
        end
    end

    // decode in phase one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op <= OP_IDLE;
            instr <= 16'h0000;
        end else if (instrReady) begin
            instr <= instrWord;
            if (!instrValid) begin
                op <= OP_IDLE;
            end else if (instrWord == `SSE_OP_SLEEP) begin
                op <= OP_SLEEP; // [RULE_06]
            end else if (instrWord[`SSE_F_OPHI] == `SSE_OP_SUBB) begin
                op <= OP_SUBB;
            end else begin
                op <= OP_OTHER;
            end
        end
    end

    // sleep does nothing in phase two; subtract reads its operand there
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fVal <= 8'h00;
        end else if (phase == PH_Q2 && op == OP_SUBB) begin
            fVal <= fileMem[fileAddr]; // [RULE_06]
        end
    end

    assign aluIf.w = wReg;
    assign aluIf.f = fVal;
    assign aluIf.flagsIn = flags;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resReg <= 8'h00;
            resFlags <= '0;
        end else if (phase == PH_Q3 && op == OP_SUBB) begin
            resReg <= aluIf.result; // [RULE_07]
            resFlags <= aluIf.flagsOut;
        end
    end

    // core write-back has priority over a bus write in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wReg <= 8'h00;
        end else if (subbNow && !instr[`SSE_F_DEST]) begin
            wReg <= resReg; // [RULE_08]
        end else if (busWr && wb_adr_i == `SSE_REG_WREG) begin
            wReg <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= '0;
        end else if (subbNow) begin
            flags <= resFlags;
        end else if (busWr && wb_adr_i == `SSE_REG_STAT) begin
            flags <= wb_dat_i[`SSE_STAT_FLAGS];
        end
    end

    always_ff @(posedge clk) begin
        if (subbNow && instr[`SSE_F_DEST]) begin
            fileMem[fileAddr] <= resReg; // [RULE_08]
        end else if (busWr && wb_adr_i == `SSE_REG_MDAT) begin
            fileMem[memAddr] <= wb_dat_i[7:0];
        end
    end

    // power state flags and sleep state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            powerdownFlag <= `SSE_POWERDOWN_RESET;
            timeoutFlag <= `SSE_TIMEOUT_RESET;
            asleep <= 1'b0;
        end else if (sleepNow) begin
            powerdownFlag <= 1'b0; // [RULE_01]
            timeoutFlag <= 1'b1; // [RULE_02]
            asleep <= 1'b1; // [RULE_04]
        end else if (wdogWake) begin
            timeoutFlag <= 1'b0; // [RULE_05]
            asleep <= 1'b0;
        end else if (pinWake) begin
            asleep <= 1'b0;
        end
    end

    // software control registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bankSelectReg <= 4'h0;
            wdogEn <= 1'b0;
            memAddr <= 12'h000;
            irqMask <= 3'h0;
        end else if (busWr) begin
            case (wb_adr_i)
                `SSE_REG_CTRL: begin
                    bankSelectReg <= wb_dat_i[`SSE_CTRL_BANK];
                    wdogEn <= wb_dat_i[`SSE_CTRL_WDOG_EN];
                end
                `SSE_REG_MADR: begin
                    memAddr[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) begin
                        memAddr[11:8] <= wb_dat_i[11:8];
                    end
                end
                `SSE_REG_IRQM: irqMask <= wb_dat_i[2:0];
                default: ;
            endcase
        end
    end

    // sticky events: a new event wins over the read that clears
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqStat <= 3'h0;
        end else begin
            if (busTake && !wb_we_i && wb_adr_i == `SSE_REG_IRQS) begin
                irqStat <= {pinWake, wdogWake, sleepNow};
            end else begin
                irqStat <= irqStat | {pinWake, wdogWake, sleepNow};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStat & irqMask);
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (wb_adr_i)
            `SSE_REG_CTRL: next_rdata[4:0] = {wdogEn, bankSelectReg};
            `SSE_REG_STAT: next_rdata[7:0] = {asleep, timeoutFlag, powerdownFlag, flags};
            `SSE_REG_WREG: next_rdata[7:0] = wReg;
            `SSE_REG_MADR: next_rdata[11:0] = memAddr;
            `SSE_REG_MDAT: next_rdata[7:0] = fileMem[memAddr];
            `SSE_REG_IRQS: next_rdata[2:0] = irqStat;
            `SSE_REG_IRQM: next_rdata[2:0] = irqMask;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= busTake;
            if (busTake && !wb_we_i) begin
                wb_dat_o <= next_rdata;
            end
        end
    end

    a_sleep_clears_pd: // [RULE_01]
        assert property (@(posedge clk) disable iff (!rst_n) sleepNow |=> !powerdownFlag)
        else $error("power-down flag not cleared by sleep");
    a_sleep_sets_to: // [RULE_02]
        assert property (@(posedge clk) disable iff (!rst_n) sleepNow |=> timeoutFlag)
        else $error("time-out flag not set by sleep");
    a_sleep_halts_core: // [RULE_04]
        assert property (@(posedge clk) disable iff (!rst_n) sleepNow |=> asleep && !oscRun && !instrReady)
        else $error("core not halted after sleep");
    a_asleep_no_exec: // [RULE_04]
        assert property (@(posedge clk) disable iff (!rst_n)
            asleep |-> !subbNow && phase == PH_Q1 && !oscRun && !instrReady)
        else $error("instruction ran while asleep");
    a_wdog_wake_tflag: // [RULE_05]
        assert property (@(posedge clk) disable iff (!rst_n) wdogWake |=> !timeoutFlag && oscRun)
        else $error("watchdog wake did not clear time-out flag");
    a_alu_result: // [RULE_07]
        assert property (@(posedge clk) disable iff (!rst_n)
            phase == PH_Q3 && op == OP_SUBB |=>
            resReg == 8'($past(wReg) - $past(fVal) - {7'h00, ~$past(flags.c)}))
        else $error("subtract with borrow result wrong");
    a_alu_carry: // [RULE_07]
        assert property (@(posedge clk) disable iff (!rst_n)
            phase == PH_Q3 && op == OP_SUBB |=>
            resFlags.c == ({1'b0, $past(wReg)} >= {1'b0, $past(fVal)} + {8'h00, ~$past(flags.c)}))
        else $error("subtract with borrow carry wrong");
    a_sleep_decode: // [RULE_06]
        assert property (@(posedge clk) disable iff (!rst_n)
            instrReady && instrValid && instrWord == `SSE_OP_SLEEP |-> ##1 $stable(wReg) ##3 asleep)
        else $error("sleep opcode not executed in one cycle");
    a_dest_wreg: // [RULE_08]
        assert property (@(posedge clk) disable iff (!rst_n)
            subbNow && !instr[`SSE_F_DEST] |=> wReg == $past(resReg))
        else $error("result not written to W");
    a_dest_file: // [RULE_08]
        assert property (@(posedge clk) disable iff (!rst_n)
            subbNow && instr[`SSE_F_DEST] |=> wReg == $past(wReg))
        else $error("W changed for file destination");
    a_bank_select: // [RULE_09]
        assert property (@(posedge clk) disable iff (!rst_n)
            phase == PH_Q2 && op == OP_SUBB |-> fileAddr[11:8] ==
            (instr[`SSE_F_ACC] ? bankSelectReg : (instr[7] ? `SSE_ACC_HI_BANK : `SSE_ACC_LO_BANK)))
        else $error("wrong bank for subtract operand");
    c_sleep: cover property (@(posedge clk) disable iff (!rst_n) sleepNow);
    c_wdog_wake: cover property (@(posedge clk) disable iff (!rst_n) wdogWake);
    c_pin_wake: cover property (@(posedge clk) disable iff (!rst_n) pinWake);
    c_subb_file: cover property (@(posedge clk) disable iff (!rst_n) subbNow && instr[`SSE_F_DEST]);
endmodule

// >>> rtl/sse_if.sv
// interfaces between the executor core, its alu and its watchdog
`timescale 1ns/1ps
interface sse_alu_if;
    logic [7:0] w;
    logic [7:0] f;
    sse_pkg::sse_flags_type flagsIn;
    logic [7:0] result;
    sse_pkg::sse_flags_type flagsOut;
    modport core (output w, f, flagsIn, input result, flagsOut);
    modport alu (input w, f, flagsIn, output result, flagsOut);
endinterface

interface sse_wdog_if;
    logic enable;
    logic clear;
    logic timeout;
    logic idle;
    modport core (output enable, clear, input timeout, idle);
    modport wdog (input enable, clear, output timeout, idle);
endinterface

// >>> rtl/sse_pkg.sv
// types for the sleep and subtract-with-borrow executor
package sse_pkg;
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} sse_phase_type;
    typedef enum logic [1:0] {OP_IDLE, OP_SLEEP, OP_SUBB, OP_OTHER} sse_op_type;
    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } sse_flags_type;
endpackage

// >>> rtl/sse_watchdog.sv
// watchdog counter with postscaler and synchronous clear
`timescale 1ns/1ps
`include "sse_cfg.svh"
module sse_watchdog #(
    parameter int BASE_CYCLES = `SSE_WDOG_CYCLES,
    parameter int POSTSCALE = `SSE_WDOG_POSTSCALE
) (
    input wire logic clk,
    input wire logic rst_n,
    sse_wdog_if.wdog ctl
);
    import sse_pkg::*;
    localparam int BW = $clog2(BASE_CYCLES + 1);
    localparam int PW = $clog2(POSTSCALE + 1);
    logic [BW-1:0] baseCnt;
    logic [PW-1:0] postCnt;
    logic baseTick;
    assign baseTick = ctl.enable && (baseCnt == BW'(BASE_CYCLES - 1));
    assign ctl.idle = (baseCnt == '0) && (postCnt == '0);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            baseCnt <= '0;
        end else if (ctl.clear || !ctl.enable || baseTick) begin
            baseCnt <= '0; // [RULE_03]
        end else begin
            baseCnt <= baseCnt + 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            postCnt <= '0;
            ctl.timeout <= 1'b0;
        end else begin
            ctl.timeout <= 1'b0;
            if (ctl.clear) begin
                postCnt <= '0; // [RULE_03]
            end else if (baseTick) begin
                if (postCnt == PW'(POSTSCALE - 1)) begin
                    postCnt <= '0;
                    ctl.timeout <= 1'b1;
                end else begin
                    postCnt <= postCnt + 1'b1;
                end
            end
        end
    end
    a_wdog_clear_zero: // [RULE_03]
        assert property (@(posedge clk) disable iff (!rst_n) ctl.clear |=> ctl.idle && !ctl.timeout)
        else $error("watchdog not cleared");
endmodule

// >>> tb/sse_exec_bench.sv
// self-checking bench for the sleep and subtract-with-borrow executor
`timescale 1ns/1ps
`include "sse_cfg.svh"
module sse_exec_bench;
    typedef struct {string name; logic [31:0] exp; logic [31:0] mask;} sse_note_type;
    localparam int BASE = 8;
    localparam int POST = 2;
    logic clk, rst_n, cyc, stb, we, ack, wakePin, stall, instrValid, instrReady, oscRun, irq;
    logic [7:0] adr, w, f, off, res;
    logic [3:0] sel, bank, bk;
    logic [31:0] wdat, rdat, rnd;
    logic [15:0] instrWord;
    logic [8:0] diff;
    logic [4:0] lo;
    logic c, d, a;
    sse_note_type notes[$];
    sse_note_type note;
    int err_count, compares, tick, lastAwake;

    sse_exec #(.WDOG_BASE_CYCLES(BASE), .WDOG_POSTSCALE(POST)) i_sse_exec (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .instrValid(instrValid), .instrWord(instrWord), .instrReady(instrReady),
        .wakePin(wakePin), .oscRun(oscRun), .irq(irq));
    sse_fetch_model i_sse_fetch_model (.clk(clk), .rst_n(rst_n), .stall(stall), .instrReady(instrReady),
        .instrValid(instrValid), .instrWord(instrWord));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        tick <= tick + 1;
        if (oscRun === 1'b1) begin
            lastAwake <= tick;
        end
        if (cyc && stb && !we && ack === 1'b1) begin
            note = notes.pop_front();
            chk(note.name, note.exp & note.mask, rdat & note.mask);
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] dt);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= ad;
        wdat <= dt;
        @(posedge clk);
        while (ack !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) begin
            err_count++;
            $display("mismatch ack expected 1 seen 0");
        end
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m, input string nm);
        notes.push_back('{nm, e, m});
        bus(1'b0, ad, 32'h0);
    endtask

    task automatic exec(input logic [15:0] word);
        int n;
        n = 0;
        i_sse_fetch_model.prog.push_back(word);
        // a random stall holds the word back a few cycles, then lets it through
        repeat (3) @(posedge clk);
        stall <= 1'b0;
        repeat (2) @(posedge clk);
        while ((i_sse_fetch_model.prog.size() != 0 || instrValid) && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= 100) begin
            err_count++;
            $display("mismatch instruction expected taken seen pending");
        end
        repeat (5) @(posedge clk);
    endtask

    task automatic wait_osc(input logic lvl, input int lim);
        int n;
        n = 0;
        while (oscRun !== lvl && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk("oscRun", {31'h0, lvl}, {31'h0, oscRun});
    endtask

    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("mismatch watchdog expected done seen hang");
        give_verdict();
    end

    initial begin
        {cyc, stb, we, wakePin, stall} = 5'h0;
        adr = 8'h0;
        wdat = 32'h0;
        sel = 4'hf;
        rnd = 32'hbf60;
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(`SSE_REG_STAT, 32'h60, 32'hff, "stat");
        rd(`SSE_REG_CTRL, 32'h0, 32'hff, "ctrl");
        rd(`SSE_REG_IRQM, 32'h0, 32'hff, "mask");
        rd(`SSE_REG_WREG, 32'h0, 32'hff, "w");
        rd(8'h1c, 32'h0, 32'hffffffff, "unmapped");
        bus(1'b1, `SSE_REG_STAT, 32'hff);
        rd(`SSE_REG_STAT, 32'h7f, 32'hff, "stat ro");
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            {bank, off, a, d, c, f, w} = rnd[30:0];
            if (i < 2) begin
                a = 1'b0;
                d = 1'b1;
                off[7] = i[0];
            end
            stall <= rnd[31];
            bk = a ? bank : (off[7] ? 4'hf : 4'h0);
            diff = {1'b0, w} - {1'b0, f} - {8'h0, ~c};
            res = diff[7:0];
            lo = {1'b0, w[3:0]} - {1'b0, f[3:0]} - {4'h0, ~c};
            bus(1'b1, `SSE_REG_CTRL, {28'h0, bank});
            bus(1'b1, `SSE_REG_WREG, {24'h0, w});
            bus(1'b1, `SSE_REG_MADR, {20'h0, bk, off});
            bus(1'b1, `SSE_REG_MDAT, {24'h0, f});
            bus(1'b1, `SSE_REG_STAT, {31'h0, c});
            exec({`SSE_OP_SUBB, d, a, off});
            rd(`SSE_REG_WREG, {24'h0, d ? w : res}, 32'hff, "w");
            rd(`SSE_REG_MDAT, {24'h0, d ? res : f}, 32'hff, "file");
            rd(`SSE_REG_STAT, {24'h0, 3'b011, res[7], (w[7] != f[7]) && (res[7] != w[7]), res == 8'h0, ~lo[4], ~diff[8]},
                32'hff, "flags");
        end
        stall <= 1'b0;
        exec(16'h0004);
        rd(`SSE_REG_STAT, 32'h60, 32'he0, "stat other op");
        chk("oscRun", 32'h1, {31'h0, oscRun});
        $display("test subtract done");
        bus(1'b1, `SSE_REG_IRQM, 32'h7);
        bus(1'b1, `SSE_REG_CTRL, 32'h10);
        repeat (13) @(posedge clk);
        exec(`SSE_OP_SLEEP);
        chk("oscRun", 32'h0, {31'h0, oscRun});
        chk("instrReady", 32'h0, {31'h0, instrReady});
        rd(`SSE_REG_STAT, 32'hc0, 32'he0, "stat asleep");
        chk("irq", 32'h1, {31'h0, irq});
        rd(`SSE_REG_IRQS, 32'h1, 32'h7, "irq status");
        wait_osc(1'b1, 200);
        chk("sleep span", 32'h1, {31'h0, (tick - lastAwake) >= 12});
        rd(`SSE_REG_STAT, 32'h0, 32'he0, "stat wdt wake");
        rd(`SSE_REG_IRQS, 32'h2, 32'h7, "irq status");
        $display("test watchdog wake done");
        bus(1'b1, `SSE_REG_CTRL, 32'h0);
        bus(1'b1, `SSE_REG_IRQM, 32'h4);
        exec(`SSE_OP_SLEEP);
        repeat (40) @(posedge clk);
        chk("oscRun", 32'h0, {31'h0, oscRun});
        chk("irq masked", 32'h0, {31'h0, irq});
        wakePin <= 1'b1;
        wait_osc(1'b1, 20);
        wakePin <= 1'b0;
        repeat (2) @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        rd(`SSE_REG_STAT, 32'h40, 32'he0, "stat pin wake");
        rd(`SSE_REG_IRQS, 32'h5, 32'h7, "irq status");
        repeat (3) @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test pin wake done");
        give_verdict();
    end
endmodule

// >>> tb/sse_fetch_model.sv
// behavioural instruction fetch path that offers one program word at a time
`timescale 1ns/1ps
module sse_fetch_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic instrReady,
    output logic instrValid,
    output logic [15:0] instrWord
);
    logic [15:0] prog[$];

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            instrValid <= 1'b0;
            instrWord <= 16'ha5a5;
        end else if (instrValid && !instrReady) begin
            // an offered word stays put until the core takes it
            instrValid <= 1'b1;
        end else if (prog.size() != 0 && !stall) begin
            instrValid <= 1'b1;
            instrWord <= prog.pop_front();
        end else begin
            // idle bus wanders so a stale word never looks fresh
            instrValid <= 1'b0;
            instrWord <= ~instrWord;
        end
    end
endmodule
